// ==== shared/i2m_pkg.sv ====
// Constants and types shared by the two-wire master sequencer
package i2m_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_BAUD = 8'h08;
    localparam logic [7:0] ADR_BUF = 8'h0c;
    // Second control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_RESTART = 1;
    localparam int CTRL_RECEIVE = 3;
    localparam int CTRL_ACK_RECEIVED_STATUS = 6;
    localparam logic [7:0] CTRL_WPROT_MASK = 8'h1f;
    localparam logic [7:0] CTRL_REQ_MASK = 8'h0b;
    // Port status register fields
    localparam int STAT_BF = 0;
    localparam int STAT_SSEEN = 1;
    localparam int STAT_WRITE_COLLISION = 2;
    localparam int STAT_OVF = 3;
    localparam int STAT_BCOL = 4;
    localparam int STAT_EVT = 5;
    localparam logic [7:0] STAT_W1C_MASK = 8'h3e;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Baud generator steps once per two system clocks
    localparam logic TICK_LAST = 1'h1;
    // Bit counts
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [3:0] BITS_ACK = 4'h8;

    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_WAIT = 12'h002,
        ST_HOLD = 12'h004,
        RS_SCLLOW = 12'h008,
        RS_SDAHI = 12'h010,
        RS_SCLREL = 12'h020,
        RS_BOTHHI = 12'h040,
        RS_SDALOW = 12'h080,
        TX_LOW = 12'h100,
        TX_HIGH = 12'h200,
        RX_LOW = 12'h400,
        RX_HIGH = 12'h800
    } i2m_state_e;
endpackage

// ==== rtl/i2m_master.sv ====
// Two-wire master sequencer: start, repeated start, transmit, receive
`timescale 1ns/1ps
`default_nettype none

module i2m_master (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] wb_adr, // Wishbone byte address
    input wire logic [31:0] wb_dat_w, // Wishbone write data
    output logic [31:0] wb_dat_r, // Wishbone read data
    input wire logic wb_we, // Wishbone write enable
    input wire logic [3:0] wb_sel, // Wishbone byte lanes
    input wire logic wb_cyc, // Wishbone cycle
    input wire logic wb_stb, // Wishbone strobe
    output logic wb_ack, // Wishbone acknowledge
    input wire logic sda_pin, // SDA line level
    output logic sda_low, // SDA drive value, always low
    output logic sda_oe, // SDA pull-down enable
    input wire logic scl_pin, // SCL line level
    output logic scl_low, // SCL drive value, always low
    output logic scl_oe // SCL pull-down enable
);
    import i2m_pkg::*;

    i2m_state_e state_q, state_d;
    logic [7:0] brg_q, brg_d;
    logic tick_q, tick_d;
    logic hi_ok_q, hi_ok_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] buf_q, buf_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] baud_q, baud_d;
    logic sda_pull_q, sda_pull_d;
    logic scl_pull_q, scl_pull_d;
    logic ack_q, ack_d;
    logic [7:0] rdat_q, rdat_d;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic scl_m_q, scl_s_q, scl_p_q;

    // Two-stage line synchronisers plus one delayed copy for edges
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
        end else begin
            sda_m_q <= sda_pin;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            scl_m_q <= scl_pin;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
        end
    end

    // Bus slave, registers and sequencer next state
    always_comb begin
        logic acc;
        logic wr;
        logic rd;
        logic busy;
        logic timeout;
        logic go_tx;
        logic abort;
        logic [7:0] st_set;
        logic [7:0] st_clr;
        logic [7:0] nshift;
        acc = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        busy = 1'b0;
        timeout = 1'b0;
        go_tx = 1'b0;
        abort = 1'b0;
        st_set = 8'h00;
        st_clr = 8'h00;
        nshift = {shift_q[6:0], sda_s_q};
        state_d = state_q;
        brg_d = brg_q;
        hi_ok_d = hi_ok_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        buf_d = buf_q;
        ctrl_d = ctrl_q;
        baud_d = baud_q;
        sda_pull_d = sda_pull_q;
        scl_pull_d = scl_pull_q;
        rdat_d = rdat_q;
        // Divider tick and down counter that rests at zero
        tick_d = ~tick_q;
        if (tick_q == TICK_LAST && brg_q != 8'h00) begin
            brg_d = brg_q - 8'h01;
        end
        timeout = (brg_q == 8'h00);
        // Single-cycle classic handshake
        acc = wb_cyc & wb_stb & ~ack_q;
        ack_d = acc;
        wr = acc & wb_we & wb_sel[0];
        rd = acc & ~wb_we;
        busy = (state_q != ST_IDLE) || ((ctrl_q & CTRL_REQ_MASK) != 8'h00);
        // Register writes
        if (wr && wb_adr == ADR_CTRL) begin
            if (!busy) begin
                ctrl_d = (ctrl_q & ~CTRL_WPROT_MASK) | (wb_dat_w[7:0] & CTRL_REQ_MASK);
            end
        end else if (wr && wb_adr == ADR_STAT) begin
            st_clr = wb_dat_w[7:0] & STAT_W1C_MASK;
        end else if (wr && wb_adr == ADR_BAUD) begin
            baud_d = wb_dat_w[7:0];
        end else if (wr && wb_adr == ADR_BUF) begin
            if (busy) begin
                st_set[STAT_WRITE_COLLISION] = 1'b1;
            end else begin
                go_tx = 1'b1;
                buf_d = wb_dat_w[7:0];
                shift_d = wb_dat_w[7:0];
                st_set[STAT_BF] = 1'b1;
                brg_d = baud_q;
                cnt_d = 4'h0;
                hi_ok_d = 1'b0;
                scl_pull_d = 1'b1;
                state_d = TX_LOW;
            end
        end
        // Register reads
        if (rd) begin
            if (wb_adr == ADR_CTRL) begin
                rdat_d = ctrl_q;
            end else if (wb_adr == ADR_STAT) begin
                rdat_d = stat_q;
            end else if (wb_adr == ADR_BAUD) begin
                rdat_d = baud_q;
            end else if (wb_adr == ADR_BUF) begin
                rdat_d = buf_q;
                if (state_q != TX_LOW && state_q != TX_HIGH) begin
                    st_clr[STAT_BF] = 1'b1;
                end
            end else begin
                rdat_d = 8'h00;
            end
        end
        // Start seen whenever SDA falls while SCL stays high
        if (sda_p_q && !sda_s_q && scl_s_q && scl_p_q) begin
            st_set[STAT_SSEEN] = 1'b1;
        end
        // Sequencer
        case (state_q)
            ST_IDLE: begin
                if (go_tx) begin
                    state_d = TX_LOW;
                end else if (ctrl_q[CTRL_START]) begin
                    if (sda_s_q && scl_s_q) begin
                        brg_d = {1'b0, baud_q[6:0]};
                        sda_pull_d = 1'b0;
                        state_d = ST_WAIT;
                    end else begin
                        abort = 1'b1;
                    end
                end else if (ctrl_q[CTRL_RESTART]) begin
                    scl_pull_d = 1'b1;
                    state_d = RS_SCLLOW;
                end else if (ctrl_q[CTRL_RECEIVE]) begin
                    sda_pull_d = 1'b0;
                    scl_pull_d = 1'b1;
                    brg_d = baud_q;
                    cnt_d = 4'h0;
                    state_d = RX_LOW;
                end
            end
            ST_WAIT: begin
                if (!scl_s_q) begin
                    abort = 1'b1;
                end else if (timeout) begin
                    if (sda_s_q) begin
                        sda_pull_d = 1'b1;
                        brg_d = baud_q;
                        state_d = ST_HOLD;
                    end else begin
                        abort = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                if (timeout) begin
                    ctrl_d[CTRL_START] = 1'b0;
                    st_set[STAT_EVT] = 1'b1;
                    scl_pull_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            RS_SCLLOW: begin
                if (!scl_s_q) begin
                    brg_d = {2'b00, baud_q[5:0]};
                    sda_pull_d = 1'b0;
                    state_d = RS_SDAHI;
                end
            end
            RS_SDAHI: begin
                if (timeout) begin
                    if (sda_s_q) begin
                        scl_pull_d = 1'b0;
                        state_d = RS_SCLREL;
                    end else begin
                        abort = 1'b1;
                    end
                end
            end
            RS_SCLREL: begin
                if (scl_s_q) begin
                    if (!sda_s_q) begin
                        abort = 1'b1;
                    end else begin
                        brg_d = baud_q;
                        state_d = RS_BOTHHI;
                    end
                end
            end
            RS_BOTHHI: begin
                if (!scl_s_q) begin
                    abort = 1'b1;
                end else if (timeout) begin
                    sda_pull_d = 1'b1;
                    brg_d = baud_q;
                    state_d = RS_SDALOW;
                end
            end
            RS_SDALOW: begin
                if (timeout) begin
                    ctrl_d[CTRL_RESTART] = 1'b0;
                    st_set[STAT_EVT] = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            TX_LOW: begin
                if (!hi_ok_q && !scl_s_q) begin
                    // Data changes only once SCL is seen low
                    hi_ok_d = 1'b1;
                    if (cnt_q == BITS_ACK) begin
                        sda_pull_d = 1'b0;
                    end else begin
                        sda_pull_d = ~shift_q[7];
                        shift_d = {shift_q[6:0], 1'b0};
                    end
                end else if (hi_ok_q && timeout) begin
                    scl_pull_d = 1'b0;
                    hi_ok_d = 1'b0;
                    state_d = TX_HIGH;
                end
            end
            TX_HIGH: begin
                if (!hi_ok_q) begin
                    if (scl_s_q) begin
                        brg_d = baud_q;
                        hi_ok_d = 1'b1;
                    end
                end else if (timeout) begin
                    scl_pull_d = 1'b1;
                    hi_ok_d = 1'b0;
                    cnt_d = cnt_q + 4'h1;
                    brg_d = baud_q;
                    state_d = TX_LOW;
                    if (cnt_q == BITS_LAST) begin
                        st_clr[STAT_BF] = 1'b1;
                    end else if (cnt_q == BITS_ACK) begin
                        ctrl_d[CTRL_ACK_RECEIVED_STATUS] = sda_s_q;
                        st_set[STAT_EVT] = 1'b1;
                        brg_d = 8'h00;
                        state_d = ST_IDLE;
                    end
                end
            end
            RX_LOW: begin
                if (timeout) begin
                    scl_pull_d = 1'b0;
                    hi_ok_d = 1'b0;
                    state_d = RX_HIGH;
                end
            end
            RX_HIGH: begin
                if (!hi_ok_q) begin
                    if (scl_s_q) begin
                        brg_d = baud_q;
                        hi_ok_d = 1'b1;
                    end
                end else if (timeout) begin
                    shift_d = nshift;
                    scl_pull_d = 1'b1;
                    cnt_d = cnt_q + 4'h1;
                    brg_d = baud_q;
                    state_d = RX_LOW;
                    if (cnt_q == BITS_LAST) begin
                        ctrl_d[CTRL_RECEIVE] = 1'b0;
                        buf_d = nshift;
                        if (stat_q[STAT_BF]) begin
                            st_set[STAT_OVF] = 1'b1;
                        end
                        st_set[STAT_BF] = 1'b1;
                        st_set[STAT_EVT] = 1'b1;
                        brg_d = 8'h00;
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Collision: flag, drop requests, release lines, go idle
        if (abort) begin
            st_set[STAT_BCOL] = 1'b1;
            ctrl_d = ctrl_d & ~CTRL_REQ_MASK;
            sda_pull_d = 1'b0;
            scl_pull_d = 1'b0;
            brg_d = 8'h00;
            state_d = ST_IDLE;
        end
        // Hardware set wins over software clear
        stat_d = (stat_q & ~st_clr) | st_set;
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            brg_q <= 8'h00;
            tick_q <= 1'b0;
            hi_ok_q <= 1'b0;
            cnt_q <= 4'h0;
            shift_q <= RST_BYTE;
            buf_q <= RST_BYTE;
            ctrl_q <= RST_CTRL;
            stat_q <= RST_STAT;
            baud_q <= RST_BAUD;
            sda_pull_q <= 1'b0;
            scl_pull_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            state_q <= state_d;
            brg_q <= brg_d;
            tick_q <= tick_d;
            hi_ok_q <= hi_ok_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            buf_q <= buf_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            baud_q <= baud_d;
            sda_pull_q <= sda_pull_d;
            scl_pull_q <= scl_pull_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Open-drain outputs and bus answer
    assign sda_low = 1'b0;
    assign scl_low = 1'b0;
    assign sda_oe = sda_pull_q;
    assign scl_oe = scl_pull_q;
    assign wb_ack = ack_q;
    assign wb_dat_r = {24'h000000, rdat_q};
endmodule

`default_nettype wire

// ==== test/i2m_master_props.sv ====
// Port assertions for the two-wire master sequencer
`timescale 1ns/1ps
`default_nettype none
module i2m_master_props import i2m_pkg::*; (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic [7:0] wb_adr, // Address
    input wire logic [31:0] wb_dat_w, // Write data
    input wire logic [31:0] wb_dat_r, // Read data
    input wire logic wb_we, // Write enable
    input wire logic [3:0] wb_sel, // Lanes
    input wire logic wb_cyc, // Cycle
    input wire logic wb_stb, // Strobe
    input wire logic wb_ack, // Acknowledge
    input wire logic sda_pin, // SDA level
    input wire logic sda_low, // SDA value
    input wire logic sda_oe, // SDA pull
    input wire logic scl_pin, // SCL level
    input wire logic scl_low, // SCL value
    input wire logic scl_oe // SCL pull
);
    logic [7:0] baud_q;
    logic [7:0] baud_d;
    logic [9:0] hi_q;
    logic [9:0] hi_d;
    logic req;
    // Request not yet answered
    assign req = wb_cyc && wb_stb && !wb_ack;
    // Reload value and cycles since SCL was let go
    always_comb begin
        baud_d = baud_q;
        hi_d = hi_q;
        if (req && wb_we && wb_sel[0] && wb_adr == ADR_BAUD)
            baud_d = wb_dat_w[7:0];
        if (scl_oe)
            hi_d = 10'h000;
        else if (hi_q != 10'h3ff)
            hi_d = hi_q + 10'h001;
    end
    always_ff @(posedge sys_clk) begin
        baud_q <= rst_n ? baud_d : RST_BAUD;
        hi_q <= rst_n ? hi_d : 10'h000;
    end
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_RST_IDLE:
        assert property ($rose(rst_n) |-> !sda_oe && !scl_oe && !wb_ack)
            else $error("line pulled or ack high after reset");
    AST_ACK_NEXT:
        assert property (req |=> wb_ack)
            else $error("request not answered next cycle");
    AST_ACK_ONE:
        assert property (wb_ack |=> !wb_ack)
            else $error("ack longer than one cycle");
    AST_OPEN_DRAIN:
        assert property (sda_low == 1'b0 && scl_low == 1'b0)
            else $error("line driven high");
    AST_SDA_FALL_SCL_HIGH:
        assert property ($rose(sda_oe) && !scl_oe |-> scl_pin)
            else $error("SDA pulled with SCL low and released");
    AST_SDA_REL_SCL_LOW:
        assert property ($fell(sda_oe) |-> $past(scl_oe))
            else $error("SDA released while SCL high");
    AST_NO_START_SDA_LOW:
        assert property (req && wb_we && wb_sel[0] && wb_adr == ADR_CTRL
            && wb_dat_w[CTRL_START] && !sda_oe && !sda_pin && !$past(sda_pin)
            && !$past(sda_pin, 2) |=> !sda_oe [*8])
            else $error("start driven on a busy line");
    AST_SCL_HIGH_TIME:
        assert property ($rose(scl_oe) |-> hi_q >= {1'b0, baud_q, 1'b0})
            else $error("SCL high shorter than a baud period");
endmodule
bind i2m_master i2m_master_props u_props (.sys_clk, .rst_n, .wb_adr, .wb_dat_w, .wb_dat_r,
    .wb_we, .wb_sel, .wb_cyc, .wb_stb, .wb_ack, .sda_pin, .sda_low, .sda_oe, .scl_pin,
    .scl_low, .scl_oe);
`default_nettype wire

// ==== test/i2m_slave_model.sv ====
// Behavioural two-wire slave: receives, sends, acknowledges, stretches
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model (
    input wire logic sys_clk, // Sampling clock
    input wire logic sda, // SDA wire
    input wire logic scl, // SCL wire
    input wire logic arm, // New byte
    input wire logic rd, // Slave sends
    input wire logic nack, // Leave ack high
    input wire logic stretch, // Hold SCL low
    input wire logic jam, // Hold SDA low
    input wire logic [7:0] tx_byte, // Byte to send
    output logic sda_oe, // Pulls SDA
    output logic scl_oe, // Pulls SCL
    output logic [7:0] got // Byte taken
);
    logic scl_q = 1'b1;
    logic drv = 1'b0;
    int nbits = 0;
    int hold = 0;
    // Released lines float to the pull-up
    assign sda_oe = drv || jam;
    assign scl_oe = hold != 0;
    // Take data on SCL rise, change it after SCL fall
    always @(posedge sys_clk) begin
        scl_q <= scl;
        if (hold != 0)
            hold <= hold - 1;
        if (arm) begin
            nbits <= 0;
            drv <= rd && !tx_byte[7];
        end else if (scl && !scl_q) begin
            if (!rd && nbits < 8)
                got <= {got[6:0], sda};
            nbits <= nbits + 1;
        end else if (!scl && scl_q) begin
            if (stretch)
                hold <= 20;
            if (rd)
                drv <= nbits < 8 && !tx_byte[7 - nbits];
            else
                drv <= nbits == 8 && !nack;
        end
    end
endmodule
`default_nettype wire

// ==== test/i2m_master_tb.sv ====
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
`default_nettype none
module i2m_master_tb;
    import i2m_pkg::*;
    localparam logic [7:0] BF = 8'h1 << STAT_BF;
    localparam logic [7:0] SSEEN = 8'h1 << STAT_SSEEN;
    localparam logic [7:0] WRITE_COLLISION = 8'h1 << STAT_WRITE_COLLISION;
    localparam logic [7:0] OVF = 8'h1 << STAT_OVF;
    localparam logic [7:0] BCOL = 8'h1 << STAT_BCOL;
    localparam logic [7:0] EVT = 8'h1 << STAT_EVT;
    localparam logic [7:0] ACK = 8'h1 << CTRL_ACK_RECEIVED_STATUS;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_we = 1'b0;
    logic [3:0] wb_sel = 4'hf;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_ack, sda_oe, scl_oe, s_sda_oe, s_scl_oe;
    logic arm = 1'b0, rd = 1'b0, nack = 1'b0, stretch = 1'b0, jam = 1'b0;
    logic [7:0] tx_byte = 8'h00, got, q, d;
    logic [7:0] adrs[5] = '{ADR_CTRL, ADR_STAT, ADR_BAUD, ADR_BUF, 8'h10};
    logic [7:0] rxq[$];
    logic [15:0] lfsr = 16'hb6b6;
    int mismatches = 0;
    int compares = 0;
    // Open-drain wires with pull-ups
    wire logic sda = ~(sda_oe | s_sda_oe);
    wire logic scl = ~(scl_oe | s_scl_oe);
    i2m_master dut (.sys_clk, .rst_n, .wb_adr, .wb_dat_w, .wb_dat_r, .wb_we, .wb_sel,
        .wb_cyc, .wb_stb, .wb_ack, .sda_pin(sda), .sda_low(), .sda_oe, .scl_pin(scl),
        .scl_low(), .scl_oe);
    i2m_slave_model slv (.sys_clk, .sda, .scl, .arm, .rd, .nack, .stretch, .jam, .tx_byte,
        .sda_oe(s_sda_oe), .scl_oe(s_scl_oe), .got);
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic give_verdict();
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] dw);
        int n = 0;
        wb_adr <= a;
        wb_we <= w;
        wb_dat_w <= {24'h0, dw};
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat_r[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(q, exp);
    endtask
    // Poll status until a flag in the mask shows
    task automatic wait_stat(input logic [7:0] m);
        int n = 0;
        q = 8'h00;
        while ((q & m) == 8'h00 && n < 3000) begin
            bus(ADR_STAT, 1'b0, 8'h00);
            n++;
        end
        if (n >= 3000) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic arm_slave(input logic r, input logic [7:0] b);
        rd <= r;
        tx_byte <= b;
        arm <= 1'b1;
        @(posedge sys_clk);
        arm <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (adrs[i]) rd_chk(adrs[i], 8'h00);
        bus(ADR_BAUD, 1'b1, 8'h04);
        rd_chk(ADR_BAUD, 8'h04);
        // Start tried while another party holds SDA low; its SDA fall reads as a start
        jam <= 1'b1;
        repeat (4) @(posedge sys_clk);
        bus(ADR_CTRL, 1'b1, 8'h01);
        wait_stat(BCOL);
        rd_chk(ADR_STAT, BCOL | SSEEN);
        rd_chk(ADR_CTRL, 8'h00);
        jam <= 1'b0;
        bus(ADR_STAT, 1'b1, 8'h3e);
        // Start with a buffer write and a control write behind it
        bus(ADR_CTRL, 1'b1, 8'h01);
        bus(ADR_BUF, 1'b1, 8'h5a);
        bus(ADR_CTRL, 1'b1, 8'h08);
        wait_stat(EVT);
        rd_chk(ADR_STAT, SSEEN | WRITE_COLLISION | EVT);
        rd_chk(ADR_CTRL, 8'h00);
        rd_chk(ADR_BUF, 8'h00);
        chk({6'h0, sda, scl}, 8'h00);
        bus(ADR_STAT, 1'b1, 8'h3e);
        // Two bytes out, acked then not, the second stretched
        for (int i = 0; i < 2; i++) begin
            d = lfsr[7:0];
            lfsr = lfsr_next(lfsr);
            nack <= i[0];
            stretch <= i[0];
            arm_slave(1'b0, 8'h00);
            bus(ADR_BUF, 1'b1, d);
            bus(ADR_BUF, 1'b1, ~d);
            bus(ADR_CTRL, 1'b1, 8'h02);
            rd_chk(ADR_STAT, WRITE_COLLISION | BF);
            wait_stat(EVT);
            chk(got, d);
            rd_chk(ADR_STAT, WRITE_COLLISION | EVT);
            rd_chk(ADR_CTRL, i[0] ? ACK : 8'h00);
            chk({7'h0, scl}, 8'h00);
            bus(ADR_STAT, 1'b1, 8'h3e);
        end
        // Three bytes in, the last one overflowing
        for (int i = 0; i < 3; i++) begin
            d = lfsr[7:0];
            lfsr = lfsr_next(lfsr);
            rxq.push_back(d);
            arm_slave(1'b1, d);
            bus(ADR_CTRL, 1'b1, 8'h08);
            if (i == 0)
                bus(ADR_BUF, 1'b1, ~d);
            wait_stat(EVT);
            rd_chk(ADR_STAT, BF | EVT | (i == 0 ? WRITE_COLLISION : 8'h00) | (i == 2 ? OVF : 8'h00));
            rd_chk(ADR_CTRL, ACK);
            bus(ADR_STAT, 1'b1, 8'h3e);
            if (i == 0)
                rd_chk(ADR_BUF, rxq.pop_front());
            rd_chk(ADR_STAT, i == 0 ? 8'h00 : BF);
        end
        // Repeated start from idle, buffer write refused meanwhile
        bus(ADR_CTRL, 1'b1, 8'h02);
        bus(ADR_BUF, 1'b1, 8'h3c);
        wait_stat(EVT);
        rd_chk(ADR_STAT, BF | SSEEN | WRITE_COLLISION | EVT);
        rd_chk(ADR_CTRL, ACK);
        chk({6'h0, sda, scl}, 8'h01);
        // Reset after the repeated start releases both lines and clears status and control
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk({6'h0, sda, scl}, 8'h03);
        rd_chk(ADR_STAT, 8'h00);
        rd_chk(ADR_CTRL, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
